// File: pkg/sar_pkg.sv
// Constants, types and register map of the reliability attribute reporter.
// Assumes one 125 MHz clock and an AXI4-Lite master reaching the task file.
// Behaviour
// RULE1: Erase entry id E5h, flags 0002h
// RULE2: Erase entry byte 3 remaining life percent
// RULE3: Erase entry bytes 4-11 erase count
// RULE4: Erase value below threshold flags exceeded
// RULE5: Id CBh counts all ECC errors; a corrected and an uncorrectable pulse in one cycle count as one
// RULE6: Id CCh counts correctable ECC errors
// RULE7: Id E8h counts flash reads, eight bytes
// RULE8: Id C7h counts UDMA CRC errors
// RULE9: Advisory counters report value byte 100
// RULE10: Advisory counters never affect status result
// RULE11: Feature D1h returns one threshold sector
// RULE12: Sector starts version 0004h, 12-byte entries
// RULE13: Checksum sits in byte 511
// RULE14: Entries hold id, threshold, zero rest
// RULE15: Advisory entries report zero threshold
// RULE16: Exceeded status loads F4h and 2Ch
// RULE17: Healthy status loads 4Fh and C2h
// RULE18: Spare value below threshold flags exceeded
// RULE19: Spare entry id C4h, flags 0003h
// RULE20: Host loads feature and keys first
// RULE21: Sum of all 512 bytes zero
// RULE22: Wrong keys abort the command
package sar_pkg;
  // Bus register byte offsets
  localparam logic [7:0] SAR_OFS_FEATURE = 8'h00;
  localparam logic [7:0] SAR_OFS_SCOUNT = 8'h04;
  localparam logic [7:0] SAR_OFS_SNUM = 8'h08;
  localparam logic [7:0] SAR_OFS_CYL_LOW = 8'h0C;
  localparam logic [7:0] SAR_OFS_CYL_HIGH = 8'h10;
  localparam logic [7:0] SAR_OFS_DRV_HEAD = 8'h14;
  localparam logic [7:0] SAR_OFS_COMMAND = 8'h18;
  localparam logic [7:0] SAR_OFS_STATUS = 8'h1C;
  localparam logic [7:0] SAR_OFS_DATA = 8'h20;
  localparam logic [7:0] SAR_OFS_THR_SPARE = 8'h24;
  localparam logic [7:0] SAR_OFS_THR_ERASE = 8'h28;
  localparam logic [7:0] SAR_OFS_ERASE_STEP = 8'h2C;
  localparam logic [7:0] SAR_OFS_LIFE = 8'h30;
  // Status register bit positions
  localparam int SAR_ST_ABORT = 0;
  localparam int SAR_ST_DRQ = 1;
  localparam int SAR_ST_EXCEEDED = 2;
  // Reset values of software settings
  localparam logic [7:0] SAR_RST_THR_SPARE = 8'h0A;
  localparam logic [7:0] SAR_RST_THR_ERASE = 8'h0A;
  localparam logic [31:0] SAR_RST_ERASE_STEP = 32'h0000_03E8;
  // Command, feature and key codes
  localparam logic [7:0] SAR_CMD_SMART = 8'hB0;
  localparam logic [7:0] SAR_FEAT_READ_DATA = 8'hD0;
  localparam logic [7:0] SAR_FEAT_READ_THR = 8'hD1;
  localparam logic [7:0] SAR_FEAT_STATUS = 8'hDA;
  localparam logic [7:0] SAR_KEY_LOW = 8'h4F;
  localparam logic [7:0] SAR_KEY_HIGH = 8'hC2;
  localparam logic [7:0] SAR_FAIL_LOW = 8'hF4;
  localparam logic [7:0] SAR_FAIL_HIGH = 8'h2C;
  // Attribute identifiers
  localparam logic [7:0] SAR_ID_SPARE = 8'hC4;
  localparam logic [7:0] SAR_ID_ERASE = 8'hE5;
  localparam logic [7:0] SAR_ID_ECC = 8'hCB;
  localparam logic [7:0] SAR_ID_CORR = 8'hCC;
  localparam logic [7:0] SAR_ID_READS = 8'hE8;
  localparam logic [7:0] SAR_ID_CRC = 8'hC7;
  // Structure contents
  localparam logic [15:0] SAR_FLAG_PREFAIL = 16'h0003;
  localparam logic [15:0] SAR_FLAG_ADVISORY = 16'h0002;
  localparam logic [15:0] SAR_STRUCT_VER = 16'h0004;
  localparam logic [15:0] SAR_CAPABILITY = 16'h0003;
  localparam logic [15:0] SAR_LAYOUT_VER = 16'h0002;
  localparam logic [7:0] SAR_FIXED_VALUE = 8'h64;
  localparam logic [7:0] SAR_LIFE_FULL = 8'h64;
  // Sector geometry
  localparam logic [8:0] SAR_ENTRY_BASE = 9'd2;
  localparam logic [8:0] SAR_ENTRY_END = 9'd362;
  localparam logic [8:0] SAR_ENTRY_LEN = 9'd12;
  localparam logic [8:0] SAR_ENTRY_USED = 9'd6;
  localparam logic [8:0] SAR_OFS_CAP = 9'd368;
  localparam logic [8:0] SAR_OFS_LAYOUT = 9'd386;
  localparam logic [8:0] SAR_OFS_CHECKSUM = 9'd511;
  // AXI responses
  localparam logic [1:0] SAR_RESP_OKAY = 2'b00;
  localparam logic [1:0] SAR_RESP_SLVERR = 2'b10;

  // Event pulses from the flash engines
  typedef struct packed {
    logic block_erase;
    logic ecc_corrected;
    logic ecc_uncorrectable;
    logic flash_read;
    logic crc_error;
  } sar_events_s;

  // Spare block figures from the bad-block manager
  typedef struct packed {
    logic [7:0] pct;
    logic [63:0] counts;
  } sar_spare_s;

  // Sector being streamed
  typedef enum logic {SAR_SECT_DATA, SAR_SECT_THR} sar_sect_e;
endpackage

// File: verilog/sar_top.sv
// Reliability attribute reporter: task file, counters and sector streamer.
// Assumes an AXI4-Lite master, event pulses one cycle wide, one clock.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sar_top
  import sar_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire sar_events_s events,
  input wire sar_spare_s spare,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic threshold_exceeded
);
  // Task file registers
  logic [7:0] feature_select_reg;
  logic [7:0] sector_count_reg;
  logic [7:0] sector_number_reg;
  logic [7:0] cylinder_low_reg;
  logic [7:0] cylinder_high_reg;
  logic [7:0] drive_head_reg;
  // Software settings
  logic [7:0] thr_spare;
  logic [7:0] thr_erase;
  logic [31:0] erase_step;
  // Counters
  logic [63:0] erase_cnt;
  logic [63:0] read_cnt;
  logic [CNT_W-1:0] ecc_cnt;
  logic [CNT_W-1:0] corr_cnt;
  logic [CNT_W-1:0] crc_cnt;
  logic [31:0] step_cnt;
  logic [7:0] life_pct;
  // Command state
  logic abort_flag;
  logic drq;
  sar_sect_e sect;
  logic [8:0] byte_idx;
  logic [7:0] csum_acc;
  // Write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Write takes effect once both halves are in and no response is pending
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire lane0 = w_strb[0];
  wire [7:0] wbyte = w_data[7:0];
  wire wr_feature = wr_fire && lane0 && (aw_addr == SAR_OFS_FEATURE);
  wire wr_scount = wr_fire && lane0 && (aw_addr == SAR_OFS_SCOUNT);
  wire wr_snum = wr_fire && lane0 && (aw_addr == SAR_OFS_SNUM);
  wire wr_cyl_low = wr_fire && lane0 && (aw_addr == SAR_OFS_CYL_LOW);
  wire wr_cyl_high = wr_fire && lane0 && (aw_addr == SAR_OFS_CYL_HIGH);
  wire wr_drv_head = wr_fire && lane0 && (aw_addr == SAR_OFS_DRV_HEAD);
  wire wr_command = wr_fire && lane0 && (aw_addr == SAR_OFS_COMMAND);
  wire wr_thr_spare = wr_fire && lane0 && (aw_addr == SAR_OFS_THR_SPARE);
  wire wr_thr_erase = wr_fire && lane0 && (aw_addr == SAR_OFS_THR_ERASE);
  wire wr_step = wr_fire && (aw_addr == SAR_OFS_ERASE_STEP);
  wire wr_mapped = (aw_addr <= SAR_OFS_ERASE_STEP) && (aw_addr[1:0] == 2'b00)
    && (aw_addr != SAR_OFS_STATUS) && (aw_addr != SAR_OFS_DATA);

  // Command decode
  // RULE22: key check
  wire keys_ok = (cylinder_low_reg == SAR_KEY_LOW) && (cylinder_high_reg == SAR_KEY_HIGH);
  wire is_smart = wr_command && (wbyte == SAR_CMD_SMART);
  wire cmd_read_data = is_smart && keys_ok && (feature_select_reg == SAR_FEAT_READ_DATA);
  // RULE11: threshold read
  wire cmd_read_thr = is_smart && keys_ok && (feature_select_reg == SAR_FEAT_READ_THR);
  wire cmd_status = is_smart && keys_ok && (feature_select_reg == SAR_FEAT_STATUS);
  wire cmd_load = cmd_read_data || cmd_read_thr;
  wire cmd_abort = wr_command && !(cmd_load || cmd_status);

  // Health decision from the two pre-fail style attributes only
  // RULE4: erase threshold
  wire erase_low = life_pct < thr_erase;
  // RULE18: spare threshold
  wire spare_low = spare.pct < thr_spare;
  // RULE10: advisory excluded
  wire exceeded = erase_low || spare_low;

  // Data port read pops one sector byte
  wire rd_data = rd_fire && (s_axi_araddr == SAR_OFS_DATA) && drq;
  wire last_byte = byte_idx == SAR_OFS_CHECKSUM;

  // Attribute entry position of the current byte
  wire [8:0] rel = byte_idx - SAR_ENTRY_BASE;
  wire [8:0] ent = rel / SAR_ENTRY_LEN;
  wire [8:0] ent_pos = rel - 9'(ent * SAR_ENTRY_LEN);
  wire in_entries = (byte_idx >= SAR_ENTRY_BASE) && (byte_idx < SAR_ENTRY_END);
  wire [3:0] pos = ent_pos[3:0];
  wire [2:0] cnt_lane = 3'(pos - 4'd4);
  wire [63:0] ecc_wide = 64'(ecc_cnt);
  wire [63:0] corr_wide = 64'(corr_cnt);
  wire [63:0] crc_wide = 64'(crc_cnt);

  // Per-entry fields of the data and threshold sectors
  logic [7:0] e_id;
  logic [15:0] e_flags;
  logic [7:0] e_value;
  logic [63:0] e_counts;
  logic [7:0] e_thr;
  logic [7:0] sect_byte;

  // Entry table
  always_comb begin
    e_id = 8'h00;
    e_flags = 16'h0000;
    e_value = 8'h00;
    e_counts = 64'h0;
    e_thr = 8'h00;
    unique case (ent[2:0])
      3'd0: begin
        // RULE19: spare identity
        e_id = SAR_ID_SPARE;
        e_flags = SAR_FLAG_PREFAIL;
        e_value = spare.pct;
        e_counts = spare.counts;
        e_thr = thr_spare;
      end
      3'd1: begin
        // RULE1: erase identity
        e_id = SAR_ID_ERASE;
        e_flags = SAR_FLAG_ADVISORY;
        // RULE2: life percent
        e_value = life_pct;
        // RULE3: erase count
        e_counts = erase_cnt;
        // RULE14: real threshold
        e_thr = thr_erase;
      end
      3'd2: begin
        // RULE5: all ECC errors
        e_id = SAR_ID_ECC;
        e_flags = SAR_FLAG_ADVISORY;
        // RULE9: fixed value
        e_value = SAR_FIXED_VALUE;
        e_counts = ecc_wide & 64'h0000_0000_FFFF_FFFF;
      end
      3'd3: begin
        // RULE6: corrected errors
        e_id = SAR_ID_CORR;
        e_flags = SAR_FLAG_ADVISORY;
        e_value = SAR_FIXED_VALUE;
        e_counts = corr_wide & 64'h0000_0000_FFFF_FFFF;
      end
      3'd4: begin
        // RULE7: read count
        e_id = SAR_ID_READS;
        e_flags = SAR_FLAG_ADVISORY;
        e_value = SAR_FIXED_VALUE;
        e_counts = read_cnt;
      end
      3'd5: begin
        // RULE8: CRC errors
        e_id = SAR_ID_CRC;
        e_flags = SAR_FLAG_ADVISORY;
        e_value = SAR_FIXED_VALUE;
        e_counts = crc_wide & 64'h0000_0000_FFFF_FFFF;
      end
      // Unused entry slots stay zero
      default: ;
    endcase
  end

  // Byte generator for both sectors
  always_comb begin
    sect_byte = 8'h00;
    if (last_byte) begin
      // RULE13: checksum position
      // RULE21: zero byte sum
      sect_byte = 8'(8'h00 - csum_acc);
    end else if (byte_idx < SAR_ENTRY_BASE) begin
      // RULE12: structure version
      sect_byte = SAR_STRUCT_VER[{byte_idx[0], 3'b000} +: 8];
    end else if (in_entries && (ent < SAR_ENTRY_USED)) begin
      if (sect == SAR_SECT_THR) begin
        // RULE14: id then threshold
        // RULE15: advisory zero threshold
        if (pos == 4'd0) sect_byte = e_id;
        if (pos == 4'd1) sect_byte = e_thr;
      end else begin
        // Data entry: id, flags, value, counts
        unique case (pos)
          4'd0: sect_byte = e_id;
          4'd1: sect_byte = e_flags[7:0];
          4'd2: sect_byte = e_flags[15:8];
          4'd3: sect_byte = e_value;
          default: sect_byte = e_counts[{cnt_lane, 3'b000} +: 8];
        endcase
      end
    end else if (sect == SAR_SECT_DATA) begin
      // Capability and layout words of the data sector
      if (byte_idx == SAR_OFS_CAP) sect_byte = SAR_CAPABILITY[7:0];
      if (byte_idx == SAR_OFS_CAP + 9'd1) sect_byte = SAR_CAPABILITY[15:8];
      if (byte_idx == SAR_OFS_LAYOUT) sect_byte = SAR_LAYOUT_VER[7:0];
      if (byte_idx == SAR_OFS_LAYOUT + 9'd1) sect_byte = SAR_LAYOUT_VER[15:8];
    end
  end

  // Read data mux
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      SAR_OFS_FEATURE: rd_word = 32'(feature_select_reg);
      SAR_OFS_SCOUNT: rd_word = 32'(sector_count_reg);
      SAR_OFS_SNUM: rd_word = 32'(sector_number_reg);
      SAR_OFS_CYL_LOW: rd_word = 32'(cylinder_low_reg);
      SAR_OFS_CYL_HIGH: rd_word = 32'(cylinder_high_reg);
      SAR_OFS_DRV_HEAD: rd_word = 32'(drive_head_reg);
      SAR_OFS_COMMAND: rd_word = 32'h0;
      SAR_OFS_STATUS: begin
        rd_word[SAR_ST_ABORT] = abort_flag;
        rd_word[SAR_ST_DRQ] = drq;
        rd_word[SAR_ST_EXCEEDED] = exceeded;
      end
      SAR_OFS_DATA: rd_word = drq ? 32'(sect_byte) : 32'h0;
      SAR_OFS_THR_SPARE: rd_word = 32'(thr_spare);
      SAR_OFS_THR_ERASE: rd_word = 32'(thr_erase);
      SAR_OFS_ERASE_STEP: rd_word = erase_step;
      SAR_OFS_LIFE: rd_word = 32'(life_pct);
      default: rd_ok = 1'b0;
    endcase
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Bus handshakes and answers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SAR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SAR_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? SAR_RESP_OKAY : SAR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? SAR_RESP_OKAY : SAR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Task file writes and status results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feature_select_reg <= 8'h00;
      sector_count_reg <= 8'h00;
      sector_number_reg <= 8'h00;
      cylinder_low_reg <= 8'h00;
      cylinder_high_reg <= 8'h00;
      drive_head_reg <= 8'h00;
      thr_spare <= SAR_RST_THR_SPARE;
      thr_erase <= SAR_RST_THR_ERASE;
      erase_step <= SAR_RST_ERASE_STEP;
    end else if (ce) begin
      if (wr_feature) feature_select_reg <= wbyte;
      if (wr_scount) sector_count_reg <= wbyte;
      if (wr_snum) sector_number_reg <= wbyte;
      if (wr_drv_head) drive_head_reg <= wbyte;
      if (wr_thr_spare) thr_spare <= wbyte;
      if (wr_thr_erase) thr_erase <= wbyte;
      if (wr_step) erase_step <= w_data;
      if (cmd_status && exceeded) begin
        // RULE16: failing signature
        cylinder_low_reg <= SAR_FAIL_LOW;
        cylinder_high_reg <= SAR_FAIL_HIGH;
      end else if (cmd_status) begin
        // RULE17: healthy signature
        cylinder_low_reg <= SAR_KEY_LOW;
        cylinder_high_reg <= SAR_KEY_HIGH;
      end else begin
        if (wr_cyl_low) cylinder_low_reg <= wbyte;
        if (wr_cyl_high) cylinder_high_reg <= wbyte;
      end
    end
  end

  // Command execution and sector streaming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_flag <= 1'b0;
      drq <= 1'b0;
      sect <= SAR_SECT_DATA;
      byte_idx <= 9'd0;
      csum_acc <= 8'h00;
      threshold_exceeded <= 1'b0;
    end else if (ce) begin
      threshold_exceeded <= exceeded;
      if (wr_command) begin
        // RULE22: abort on bad keys
        abort_flag <= cmd_abort;
        drq <= cmd_load;
        sect <= cmd_read_thr ? SAR_SECT_THR : SAR_SECT_DATA;
        byte_idx <= 9'd0;
        csum_acc <= 8'h00;
      end else if (rd_data) begin
        // RULE11: one sector only
        drq <= !last_byte;
        byte_idx <= byte_idx + 9'd1;
        csum_acc <= csum_acc + sect_byte;
      end
    end
  end

  // Event counters; erase budget steps life down one percent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_cnt <= 64'h0;
      read_cnt <= 64'h0;
      ecc_cnt <= '0;
      corr_cnt <= '0;
      crc_cnt <= '0;
      step_cnt <= 32'h0;
      life_pct <= SAR_LIFE_FULL;
    end else if (ce) begin
      if (events.block_erase) begin
        erase_cnt <= erase_cnt + 64'h1;
        if (step_cnt + 32'h1 >= erase_step) begin
          step_cnt <= 32'h0;
          if (life_pct != 8'h00) life_pct <= life_pct - 8'h01;
        end else begin
          step_cnt <= step_cnt + 32'h1;
        end
      end
      if (events.flash_read) read_cnt <= read_cnt + 64'h1;
      // RULE5: either kind counts
      if (events.ecc_corrected || events.ecc_uncorrectable) ecc_cnt <= ecc_cnt + 1'b1;
      if (events.ecc_corrected) corr_cnt <= corr_cnt + 1'b1;
      if (events.crc_error) crc_cnt <= crc_cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb/sar_assertions.sv
// Checker for the reporter's bus handshakes and exceeded flag.
// Assumes a bind onto sar_top; sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module sar_chk
  import sar_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire sar_events_s events,
  input wire sar_spare_s spare,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic threshold_exceeded
);
  // One clock and one reset for every property
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write answer stands until accepted
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  // Read answer and its data stand until accepted
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer moved early");
  // Read answer one cycle after the address is taken
  property p_rlat;
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  // Write answer two cycles after both halves are taken together
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce ##1 ce |=> s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  // No new write while a response is pending
  property p_wblock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblock: assert property (p_wblock) else $error("write taken during response");
  // No new read while read data is pending
  property p_rblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblock: assert property (p_rblock) else $error("read taken during response");
  // Unmapped read answers an error with zero data
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && ce && s_axi_araddr > SAR_OFS_LIFE
      |=> s_axi_rresp == SAR_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // Clock enable low freezes the outputs
  property p_freeze;
    !ce |=> $stable(s_axi_rvalid) && $stable(s_axi_bvalid) && $stable(threshold_exceeded);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_quiet;
    (!events.block_erase && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid && $stable(spare))
      [*4] |-> $stable(threshold_exceeded);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag moved without cause");
endmodule
`default_nettype wire

// File: tb/sar_host.sv
// Host model: AXI4-Lite master reaching the task file registers.
// Assumes one clock; tasks are called from the bench's main thread.
`timescale 1ns/1ns
`default_nettype none
module sar_host
  import sar_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // Offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Hold the read address until taken, then wait for data
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] lo);
    logic [1:0] r;
    wr(SAR_OFS_FEATURE, {24'h0, f}, r);
    wr(SAR_OFS_CYL_LOW, {24'h0, lo}, r);
    wr(SAR_OFS_CYL_HIGH, {24'h0, SAR_KEY_HIGH}, r);
    wr(SAR_OFS_COMMAND, {24'h0, SAR_CMD_SMART}, r);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_smart_attribute_reporter.sv
// Bench for the attribute reporter: host model, event pulses, sector checks.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_smart_attribute_reporter
  import sar_pkg::*;
;
  logic aclk, aresetn, ce, threshold_exceeded;
  sar_events_s events;
  sar_spare_s spare;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [7:0] sec [512];
  // Expected id, value, count per slot
  localparam logic [7:0] IDS [6] = '{SAR_ID_SPARE, SAR_ID_ERASE, SAR_ID_ECC, SAR_ID_CORR,
    SAR_ID_READS, SAR_ID_CRC};
  logic [7:0] vals [6] = '{8'h50, 8'h62, 8'h64, 8'h64, 8'h64, 8'h64};
  logic [63:0] cnt [6] = '{64'h0123_4567_89AB_CDEF, 64'h5, 64'h5, 64'h3, 64'h7, 64'h4};
  sar_top #(.CNT_W(32)) uut (.*);
  sar_host u_host (.*);
  // Clock, 8 ns period
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Compare and count
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  // Read a register and compare response and data
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    u_host.rd(a, rv, rs);
    chk({rs, rv}, {r, e});
  endtask
  // One-cycle event pulses with a gap
  task automatic pulse(input int n, input sar_events_s e);
    repeat (n) begin
      @(posedge aclk);
      events <= e;
      @(posedge aclk);
      events <= '0;
    end
  endtask
  // Fetch a whole sector, then check its frame
  task automatic get_sector(input logic [7:0] f);
    logic [7:0] sum;
    sum = 8'h00;
    u_host.cmd(f, SAR_KEY_LOW);
    for (int i = 0; i < 512; i++) begin
      u_host.rd(SAR_OFS_DATA, rv, rs);
      sec[i] = rv[7:0];
      sum += rv[7:0];
    end
    chk({sec[1], sec[0]}, SAR_STRUCT_VER);
    chk(sum, 8'h00);
    u_host.rd(SAR_OFS_STATUS, rv, rs);
    chk(rv[SAR_ST_DRQ], 1'b0);
    rdchk(SAR_OFS_DATA, 32'h0, SAR_RESP_OKAY);
  endtask
  // Status command and its cylinder answer
  task automatic status_chk(input logic bad);
    u_host.cmd(SAR_FEAT_STATUS, SAR_KEY_LOW);
    rdchk(SAR_OFS_CYL_LOW, bad ? SAR_FAIL_LOW : SAR_KEY_LOW, SAR_RESP_OKAY);
    rdchk(SAR_OFS_CYL_HIGH, bad ? SAR_FAIL_HIGH : SAR_KEY_HIGH, SAR_RESP_OKAY);
    chk(threshold_exceeded, bad);
  endtask
  // Counts, verdict, end of run
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [63:0] q;
    logic [7:0] ex [511];
    logic [5:0] found;
    int b;
    aresetn = 1'b0;
    ce = 1'b1;
    events = '0;
    spare = {8'h50, 64'h0123_4567_89AB_CDEF};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(SAR_OFS_THR_SPARE, SAR_RST_THR_SPARE, SAR_RESP_OKAY);
    rdchk(SAR_OFS_THR_ERASE, SAR_RST_THR_ERASE, SAR_RESP_OKAY);
    rdchk(SAR_OFS_ERASE_STEP, SAR_RST_ERASE_STEP, SAR_RESP_OKAY);
    rdchk(SAR_OFS_LIFE, SAR_LIFE_FULL, SAR_RESP_OKAY);
    rdchk(8'h40, 32'h0, SAR_RESP_SLVERR);
    u_host.wr(8'h44, 32'h0, rs);
    chk(rs, SAR_RESP_SLVERR);
    u_host.wr(SAR_OFS_SNUM, 32'h5A, rs);
    rdchk(SAR_OFS_SNUM, 32'h5A, SAR_RESP_OKAY);
    $display("done: registers");
    // Counters: erase, corrected, uncorrectable, read, crc
    u_host.wr(SAR_OFS_ERASE_STEP, 32'h2, rs);
    pulse(5, 5'h10);
    pulse(3, 5'h08);
    pulse(2, 5'h04);
    pulse(7, 5'h02);
    pulse(4, 5'h01);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    rdchk(SAR_OFS_LIFE, 32'h62, SAR_RESP_OKAY);
    get_sector(SAR_FEAT_READ_DATA);
    found = '0;
    for (int i = 0; i < 6; i++) begin
      b = 2 + 12 * i;
      for (int j = 0; j < 6; j++) begin
        if (sec[b] === IDS[j]) begin
          found[j] = 1'b1;
          chk({sec[b + 2], sec[b + 1]}, j ? SAR_FLAG_ADVISORY : SAR_FLAG_PREFAIL);
          chk(sec[b + 3], vals[j]);
          for (int k = 0; k < 8; k++) q[8*k +: 8] = sec[b + 4 + k];
          chk(q, cnt[j]);
        end
      end
    end
    chk(found, 6'h3F);
    $display("done: data sector");
    get_sector(SAR_FEAT_READ_THR);
    ex = '{default: 8'h00};
    ex[0] = SAR_STRUCT_VER[7:0];
    for (int i = 0; i < 6; i++) ex[2 + 12 * i] = IDS[i];
    ex[3] = SAR_RST_THR_SPARE;
    ex[15] = SAR_RST_THR_ERASE;
    for (int i = 0; i < 511; i++) chk(sec[i], ex[i]);
    $display("done: threshold sector");
    status_chk(1'b0);
    spare.pct <= 8'h05;
    status_chk(1'b1);
    spare.pct <= 8'h50;
    u_host.wr(SAR_OFS_THR_ERASE, 32'h63, rs);
    status_chk(1'b1);
    u_host.wr(SAR_OFS_THR_ERASE, 32'h62, rs);
    status_chk(1'b0);
    $display("done: status");
    u_host.cmd(SAR_FEAT_READ_DATA, 8'h4E);
    rdchk(SAR_OFS_STATUS, 32'h1, SAR_RESP_OKAY);
    $display("done: bad keys");
    close_out();
  end
endmodule
bind sar_top sar_chk u_chk (.*);
`default_nettype wire
